// ==== rtl/pbg_cfg.svh ====
/*
 * constants of the port b block: register offsets, reset values, field positions.
 * assumes inclusion by bare name from package and modules.
 */
`ifndef PBG_CFG_SVH
`define PBG_CFG_SVH

`define PBG_DIR_OFS      16'hffd4
`define PBG_DATA_OFS     16'hffd6
`define PBG_DIR_RST      8'h00
`define PBG_DATA_RST     8'h00
`define PBG_DIR_READ     32'hffff_ffff
`define PBG_ZERO_WORD    32'h0000_0000
`define PBG_PIN_CS       3
`define PBG_PIN_ADC_TRIGGER_IN    7
`define PBG_PIN_DMA_REQUEST_ONE_IN    7
`define PBG_PIN_DMA_REQUEST_ZERO_IN    6
`define PBG_MODE_SINGLE  3'h7

`endif

// ==== rtl/pbg_pkg.sv ====
/*
 * types of the port b block.
 * assumes pbg_cfg.svh is on the include path.
 */
package pbg_pkg;
    `include "pbg_cfg.svh"

    typedef enum logic [1:0] {
        PBG_BUS_IDLE,
        PBG_BUS_ACCESS
    } pbg_bus_state_t;

    typedef struct packed {
        logic [7:0] dir;
        logic [7:0] data;
    } pbg_port_regs_t;

    typedef struct packed {
        pbg_bus_state_t state;
        logic [31:0]    prdata;
    } pbg_bus_regs_t;

    // each register is one word: its index times four is the byte address
    function automatic logic pbg_addr_hit(input logic [31:0] addr, input logic [15:0] ofs);
        pbg_addr_hit = (addr[17:2] == ofs) && (addr[1:0] == 2'b00);
    endfunction : pbg_addr_hit
endpackage : pbg_pkg

// ==== rtl/pbg_apb_slave.sv ====
/*
 * apb slave front end: one wait-free access phase, registered read data.
 * assumes the parent supplies the read word for the addressed register.
 */
`timescale 1ns/10ps
`include "pbg_cfg.svh"
module pbg_apb_slave
    import pbg_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] rd_word,
    input  wire logic        rd_hit,
    output logic             pready,
    output logic             pslverr,
    output logic [31:0]      prdata,
    output logic             wr_stb
);
    pbg_bus_regs_t bus_reg;
    pbg_bus_regs_t bus_next;

    always_comb begin
        bus_next = bus_reg;
        bus_next.state = (psel && !penable) ? PBG_BUS_ACCESS : PBG_BUS_IDLE;
        if (psel && !penable && !pwrite) begin
            bus_next.prdata = rd_hit ? rd_word : `PBG_ZERO_WORD;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            bus_reg <= '{state: PBG_BUS_IDLE, prdata: `PBG_ZERO_WORD};
        end else begin
            bus_reg <= bus_next;
        end
    end

    assign pready  = 1'b1;
    // an access phase without its setup cycle neither writes nor flags an error
    assign pslverr = psel && penable && (bus_reg.state == PBG_BUS_ACCESS) && !rd_hit;
    assign prdata  = bus_reg.prdata;
    assign wr_stb  = psel && penable && pwrite && (bus_reg.state == PBG_BUS_ACCESS) && rd_hit;
endmodule : pbg_apb_slave

// ==== rtl/pbg_pin_mux.sv ====
/*
 * per-pin selection between plain port drive and peripheral functions.
 * assumes peripheral enables come from the owning modules.
 */
`timescale 1ns/10ps
module pbg_pin_mux
    import pbg_pkg::*;
(
    input  wire logic [7:0] dir,
    input  wire logic [7:0] data,
    input  wire logic       cs_sel,
    input  wire logic       chip_select_seven_out,
    input  wire logic [7:0] pattern_en,
    input  wire logic [7:0] pattern_val,
    input  wire logic [1:0] timer4_compl_en,
    input  wire logic [1:0] timer4_compl_val,
    input  wire logic [3:0] capcomp_oe,
    input  wire logic [3:0] capcomp_val,
    output logic      [7:0] pin_out,
    output logic      [7:0] pin_oe_b
);
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            pin_out[i]  = data[i];
            pin_oe_b[i] = !dir[i];
            if (dir[i] && pattern_en[i]) begin
                pin_out[i] = pattern_val[i];
            end
        end
        for (int j = 0; j < 4; j++) begin
            if (capcomp_oe[j]) begin
                pin_out[j]  = capcomp_val[j];
                pin_oe_b[j] = 1'b0;
            end
        end
        for (int k = 0; k < 2; k++) begin
            if (timer4_compl_en[k]) begin
                pin_out[4+k]  = timer4_compl_val[k];
                pin_oe_b[4+k] = 1'b0;
            end
        end
        if (cs_sel) begin
            pin_out[6]  = chip_select_seven_out;
            pin_oe_b[6] = 1'b0;
        end
    end
endmodule : pbg_pin_mux

// ==== rtl/pbg_port_b.sv ====
/*
 * port b general purpose i/o with shared peripheral pins, apb register access.
 * assumes apb master in the clk domain; pin inputs synchronous to clk.
 */
// Added by the designer: register access over APB.
//
// Functional notes
// - eight pins, each separately input or output.
// - reset or hardware standby makes every pin an input; code still lets capcomp_oe, timer4_compl_en and cs_sel drive their pins.
// - direction bit 1 means output, 0 means input.
// - direction register is write-only; reads return all ones.
// - direction clears on reset and hardware standby, holds in software standby.
// - output pins keep driving through software standby.
// - chip-select-7 on pin 6 only in modes 1 to 6.
// - pins carry pattern, timer, dma request and a/d trigger functions.
// - unclaimed pins stay plain general-purpose i/o.
// - direction at 0xffd4, data at 0xffd6, low 16 address bits; code matches these as word indices on paddr[17:2], byte address times four.
// - data read gives stored bit for outputs, pin level for inputs.
// - data register clears on reset and hardware standby, holds in software standby.
`timescale 1ns/10ps
`include "pbg_cfg.svh"
module pbg_port_b
    import pbg_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic        hw_standby,
    input  wire logic        sw_standby,
    input  wire logic [2:0]  op_mode,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic             pslverr,
    output logic [31:0]      prdata,
    input  wire logic [7:0]  pin_in,
    output logic      [7:0]  pin_out,
    output logic      [7:0]  pin_oe_b,
    input  wire logic        cs7_enable,
    input  wire logic        chip_select_seven_out,
    input  wire logic [7:0]  pattern_en,
    input  wire logic [7:0]  pattern_val,
    input  wire logic [1:0]  timer4_compl_en,
    input  wire logic [1:0]  timer4_compl_val,
    input  wire logic [3:0]  capcomp_oe,
    input  wire logic [3:0]  capcomp_val,
    output logic [3:0]       capcomp_in,
    output logic             dma_request_one_in,
    output logic             dma_request_zero_in,
    output logic             adc_trigger_in
);
    ////////////////////////////////////////////////////////////////////////////
    pbg_port_regs_t port_reg;
    pbg_port_regs_t port_next;
    logic           hit_dir;
    logic           hit_data;
    logic [31:0]    rd_word;
    logic           wr_stb;
    logic           cs_sel;

    assign hit_dir  = pbg_addr_hit(paddr, `PBG_DIR_OFS);
    assign hit_data = pbg_addr_hit(paddr, `PBG_DATA_OFS);

    always_comb begin
        rd_word = `PBG_ZERO_WORD;
        if (hit_dir) begin
            rd_word = `PBG_DIR_READ;
        end else if (hit_data) begin
            rd_word = {24'h00_0000, (port_reg.data & port_reg.dir)
                       | (pin_in & ~port_reg.dir)};
        end
    end

    pbg_apb_slave u_bus (
        .clk     (clk),
        .rst_b   (rst_b),
        .psel    (psel),
        .penable (penable),
        .pwrite  (pwrite),
        .rd_word (rd_word),
        .rd_hit  (hit_dir || hit_data),
        .pready  (pready),
        .pslverr (pslverr),
        .prdata  (prdata),
        .wr_stb  (wr_stb)
    );

    ////////////////////////////////////////////////////////////////////////////
    // software standby touches nothing: registers simply hold
    always_comb begin
        port_next = port_reg;
        if (hw_standby) begin
            port_next.dir  = `PBG_DIR_RST;
            port_next.data = `PBG_DATA_RST;
        end else if (wr_stb && hit_dir) begin
            port_next.dir = pwdata[7:0];
        end else if (wr_stb && hit_data) begin
            port_next.data = pwdata[7:0];
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            port_reg <= '{dir: `PBG_DIR_RST, data: `PBG_DATA_RST};
        end else begin
            port_reg <= port_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    assign cs_sel = cs7_enable && (op_mode != `PBG_MODE_SINGLE)
                    && (op_mode != 3'h0);

    pbg_pin_mux u_mux (
        .dir                   (port_reg.dir),
        .data                  (port_reg.data),
        .cs_sel                (cs_sel),
        .chip_select_seven_out (chip_select_seven_out),
        .pattern_en            (pattern_en),
        .pattern_val           (pattern_val),
        .timer4_compl_en       (timer4_compl_en),
        .timer4_compl_val      (timer4_compl_val),
        .capcomp_oe            (capcomp_oe),
        .capcomp_val           (capcomp_val),
        .pin_out               (pin_out),
        .pin_oe_b              (pin_oe_b)
    );

    assign capcomp_in          = pin_in[`PBG_PIN_CS:0];
    assign dma_request_one_in  = pin_in[`PBG_PIN_DMA_REQUEST_ONE_IN];
    assign dma_request_zero_in = pin_in[`PBG_PIN_DMA_REQUEST_ZERO_IN];
    assign adc_trigger_in      = pin_in[`PBG_PIN_ADC_TRIGGER_IN];

    ////////////////////////////////////////////////////////////////////////////
    property p_reset_inputs;
        @(posedge clk) $rose(rst_b) |-> (pin_oe_b == 8'hff) || (|capcomp_oe)
            || (|timer4_compl_en) || cs_sel;
    endproperty
    a_reset_inputs: assert property (p_reset_inputs) else $error("pins not input");

    property p_hws_clear;
        @(posedge clk) disable iff (!rst_b) hw_standby |=> (port_reg.dir == 8'h00)
            && (port_reg.data == 8'h00);
    endproperty
    a_hws_clear: assert property (p_hws_clear) else $error("standby did not clear");

    property p_dir_read;
        @(posedge clk) disable iff (!rst_b) (psel && !penable && !pwrite && hit_dir)
            |=> prdata == 32'hffff_ffff;
    endproperty
    a_dir_read: assert property (p_dir_read) else $error("direction read not all ones");

    property p_sws_hold;
        @(posedge clk) disable iff (!rst_b) (sw_standby && !hw_standby && !wr_stb)
            |=> $stable(port_reg);
    endproperty
    a_sws_hold: assert property (p_sws_hold) else $error("state lost in standby");

    property p_dir_write;
        @(posedge clk) disable iff (!rst_b) (wr_stb && hit_dir && !hw_standby)
            |=> port_reg.dir == $past(pwdata[7:0]);
    endproperty
    a_dir_write: assert property (p_dir_write) else $error("direction write lost");

    property p_data_read;
        @(posedge clk) disable iff (!rst_b) (psel && !penable && !pwrite && hit_data)
            |=> prdata[7:0] == (($past(port_reg.data) & $past(port_reg.dir))
            | ($past(pin_in) & ~$past(port_reg.dir)));
    endproperty
    a_data_read: assert property (p_data_read) else $error("data read mismatch");

    property p_cs_mode7;
        @(posedge clk) disable iff (!rst_b) (op_mode == `PBG_MODE_SINGLE) && !port_reg.dir[6]
            |-> pin_oe_b[6];
    endproperty
    a_cs_mode7: assert property (p_cs_mode7) else $error("chip select in mode 7");

    property p_plain_drive;
        @(posedge clk) disable iff (!rst_b) (port_reg.dir[7] && !pattern_en[7])
            |-> !pin_oe_b[7] && (pin_out[7] == port_reg.data[7]);
    endproperty
    a_plain_drive: assert property (p_plain_drive) else $error("pin 7 not driven");

    property p_input_float;
        @(posedge clk) disable iff (!rst_b) !port_reg.dir[7] |-> pin_oe_b[7];
    endproperty
    a_input_float: assert property (p_input_float) else $error("input pin 7 driven");

    ////////////////////////////////////////////////////////////////////////////
    property p_data_write;
        @(posedge clk) disable iff (!rst_b) (wr_stb && hit_data && !hw_standby)
            |=> port_reg.data == $past(pwdata[7:0]);
    endproperty
    a_data_write: assert property (p_data_write) else $error("data write lost");

    property p_miss_keep;
        @(posedge clk) disable iff (!rst_b) (psel && penable && pwrite && !hit_dir && !hit_data
            && !hw_standby) |=> $stable(port_reg);
    endproperty
    a_miss_keep: assert property (p_miss_keep) else $error("unmapped write landed");

    property p_miss_err;
        @(posedge clk) disable iff (!rst_b) (psel && penable && !hit_dir && !hit_data)
            |-> pslverr;
    endproperty
    a_miss_err: assert property (p_miss_err) else $error("unmapped access not flagged");

    property p_hit_ok;
        @(posedge clk) disable iff (!rst_b) (psel && penable && (hit_dir || hit_data))
            |-> !pslverr;
    endproperty
    a_hit_ok: assert property (p_hit_ok) else $error("mapped access flagged");

    property p_read_stands;
        @(posedge clk) disable iff (!rst_b) !(psel && !penable && !pwrite)
            |=> $stable(prdata);
    endproperty
    a_read_stands: assert property (p_read_stands) else $error("read data moved");

    property p_miss_read;
        @(posedge clk) disable iff (!rst_b) (psel && !penable && !pwrite && !hit_dir
            && !hit_data) |=> prdata == 32'h0000_0000;
    endproperty
    a_miss_read: assert property (p_miss_read) else $error("unmapped read not zero");

    property p_data_upper;
        @(posedge clk) disable iff (!rst_b) (psel && !penable && !pwrite && hit_data)
            |=> prdata[31:8] == 24'h00_0000;
    endproperty
    a_data_upper: assert property (p_data_upper) else $error("upper read bits set");

    property p_hws_pins;
        @(posedge clk) disable iff (!rst_b) hw_standby |=> (pin_oe_b == 8'hff)
            || (|capcomp_oe) || (|timer4_compl_en) || cs_sel;
    endproperty
    a_hws_pins: assert property (p_hws_pins) else $error("pins driven in standby");

    property p_pattern_drive;
        @(posedge clk) disable iff (!rst_b) (port_reg.dir[7] && pattern_en[7])
            |-> !pin_oe_b[7] && (pin_out[7] == pattern_val[7]);
    endproperty
    a_pattern_drive: assert property (p_pattern_drive) else $error("pattern lost");

    property p_pattern_gate;
        @(posedge clk) disable iff (!rst_b) (!port_reg.dir[0] && pattern_en[0]
            && !capcomp_oe[0]) |-> pin_oe_b[0];
    endproperty
    a_pattern_gate: assert property (p_pattern_gate) else $error("pattern ungated");

    property p_capcomp_drive;
        @(posedge clk) disable iff (!rst_b) capcomp_oe[3]
            |-> !pin_oe_b[3] && (pin_out[3] == capcomp_val[3]);
    endproperty
    a_capcomp_drive: assert property (p_capcomp_drive) else $error("timer pin lost");

    property p_compl_drive;
        @(posedge clk) disable iff (!rst_b) timer4_compl_en[1]
            |-> !pin_oe_b[5] && (pin_out[5] == timer4_compl_val[1]);
    endproperty
    a_compl_drive: assert property (p_compl_drive) else $error("compl pin lost");

    property p_cs_drive;
        @(posedge clk) disable iff (!rst_b) cs_sel
            |-> !pin_oe_b[6] && (pin_out[6] == chip_select_seven_out);
    endproperty
    a_cs_drive: assert property (p_cs_drive) else $error("chip select lost");

    ////////////////////////////////////////////////////////////////////////////
    property p_plain_drive0;
        @(posedge clk) disable iff (!rst_b) port_reg.dir[0] && !pattern_en[0]
            && !capcomp_oe[0] |-> !pin_oe_b[0] && (pin_out[0] == port_reg.data[0]);
    endproperty
    a_plain_drive0: assert property (p_plain_drive0) else $error("pin 0 not driven");

    property p_plain_drive1;
        @(posedge clk) disable iff (!rst_b) port_reg.dir[1] && !pattern_en[1]
            && !capcomp_oe[1] |-> !pin_oe_b[1] && (pin_out[1] == port_reg.data[1]);
    endproperty
    a_plain_drive1: assert property (p_plain_drive1) else $error("pin 1 not driven");

    property p_plain_drive2;
        @(posedge clk) disable iff (!rst_b) port_reg.dir[2] && !pattern_en[2]
            && !capcomp_oe[2] |-> !pin_oe_b[2] && (pin_out[2] == port_reg.data[2]);
    endproperty
    a_plain_drive2: assert property (p_plain_drive2) else $error("pin 2 not driven");

    property p_plain_drive3;
        @(posedge clk) disable iff (!rst_b) port_reg.dir[3] && !pattern_en[3]
            && !capcomp_oe[3] |-> !pin_oe_b[3] && (pin_out[3] == port_reg.data[3]);
    endproperty
    a_plain_drive3: assert property (p_plain_drive3) else $error("pin 3 not driven");

    property p_plain_drive4;
        @(posedge clk) disable iff (!rst_b) port_reg.dir[4] && !pattern_en[4]
            && !timer4_compl_en[0] |-> !pin_oe_b[4] && (pin_out[4] == port_reg.data[4]);
    endproperty
    a_plain_drive4: assert property (p_plain_drive4) else $error("pin 4 not driven");

    property p_plain_drive5;
        @(posedge clk) disable iff (!rst_b) port_reg.dir[5] && !pattern_en[5]
            && !timer4_compl_en[1] |-> !pin_oe_b[5] && (pin_out[5] == port_reg.data[5]);
    endproperty
    a_plain_drive5: assert property (p_plain_drive5) else $error("pin 5 not driven");

    property p_plain_drive6;
        @(posedge clk) disable iff (!rst_b) port_reg.dir[6] && !pattern_en[6]
            && !cs_sel |-> !pin_oe_b[6] && (pin_out[6] == port_reg.data[6]);
    endproperty
    a_plain_drive6: assert property (p_plain_drive6) else $error("pin 6 not driven");

    property p_input_float0;
        @(posedge clk) disable iff (!rst_b) !port_reg.dir[0]
            && !capcomp_oe[0] |-> pin_oe_b[0];
    endproperty
    a_input_float0: assert property (p_input_float0) else $error("pin 0 driven");

    property p_input_float1;
        @(posedge clk) disable iff (!rst_b) !port_reg.dir[1]
            && !capcomp_oe[1] |-> pin_oe_b[1];
    endproperty
    a_input_float1: assert property (p_input_float1) else $error("pin 1 driven");

    property p_input_float2;
        @(posedge clk) disable iff (!rst_b) !port_reg.dir[2]
            && !capcomp_oe[2] |-> pin_oe_b[2];
    endproperty
    a_input_float2: assert property (p_input_float2) else $error("pin 2 driven");

    property p_input_float3;
        @(posedge clk) disable iff (!rst_b) !port_reg.dir[3]
            && !capcomp_oe[3] |-> pin_oe_b[3];
    endproperty
    a_input_float3: assert property (p_input_float3) else $error("pin 3 driven");

    property p_input_float4;
        @(posedge clk) disable iff (!rst_b) !port_reg.dir[4]
            && !timer4_compl_en[0] |-> pin_oe_b[4];
    endproperty
    a_input_float4: assert property (p_input_float4) else $error("pin 4 driven");

    property p_input_float5;
        @(posedge clk) disable iff (!rst_b) !port_reg.dir[5]
            && !timer4_compl_en[1] |-> pin_oe_b[5];
    endproperty
    a_input_float5: assert property (p_input_float5) else $error("pin 5 driven");

    property p_input_float6;
        @(posedge clk) disable iff (!rst_b) !port_reg.dir[6]
            && !cs_sel |-> pin_oe_b[6];
    endproperty
    a_input_float6: assert property (p_input_float6) else $error("pin 6 driven");
endmodule : pbg_port_b

// ==== verif/port_b_gpio_pin_mux_test.sv ====
/*
 * self-checking bench of the port b block: apb access, pin drive, standby, shared pins.
 * assumes pbg_pkg is compiled first and pbg_cfg.svh is on the include path.
 */
`timescale 1ns/10ps
`include "pbg_cfg.svh"
module port_b_gpio_pin_mux_test;
    localparam logic [7:0]  EXT    = 8'hbc;
    localparam logic [31:0] A_DIR  = {14'h0012, `PBG_DIR_OFS, 2'b00};
    localparam logic [31:0] A_DATA = {14'h0000, `PBG_DATA_OFS, 2'b00};
    localparam logic [31:0] A_NONE = {14'h0000, 16'hffd8, 2'b00};
    logic        clk        = 1'b0;
    logic        rst_b      = 1'b0;
    logic        hw_standby = 1'b0;
    logic        sw_standby = 1'b0;
    logic [2:0]  op_mode    = 3'h7;
    logic        psel       = 1'b0;
    logic        penable    = 1'b0;
    logic        pwrite     = 1'b0;
    logic [31:0] paddr      = 32'h0000_0000;
    logic [31:0] pwdata     = 32'h0000_0000;
    logic        cs7_en     = 1'b0;
    logic        cs7_val    = 1'b1;
    logic [7:0]  pat_en     = 8'h00;
    logic [7:0]  pat_val    = 8'h00;
    logic [1:0]  tc_en      = 2'h0;
    logic [1:0]  tc_val     = 2'h0;
    logic [3:0]  cc_oe      = 4'h0;
    logic [3:0]  cc_val     = 4'h0;
    logic        pready, pslverr, dma1, dma0, adc_trig, err;
    logic [31:0] prdata, rd;
    logic [7:0]  pin_lvl, pin_out, pin_oe_b;
    logic [3:0]  cc_in;
    int          n_fail   = 0;
    int          compares = 0;

    // pin level: outside world drives EXT wherever the block lets go
    assign pin_lvl = (pin_oe_b & EXT) | (~pin_oe_b & pin_out);
    always #25 clk = ~clk;

    pbg_port_b dut (
        .clk(clk), .rst_b(rst_b), .hw_standby(hw_standby), .sw_standby(sw_standby),
        .op_mode(op_mode), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
        .prdata(prdata), .pin_in(pin_lvl), .pin_out(pin_out), .pin_oe_b(pin_oe_b),
        .cs7_enable(cs7_en), .chip_select_seven_out(cs7_val), .pattern_en(pat_en),
        .pattern_val(pat_val), .timer4_compl_en(tc_en), .timer4_compl_val(tc_val),
        .capcomp_oe(cc_oe), .capcomp_val(cc_val), .capcomp_in(cc_in),
        .dma_request_one_in(dma1), .dma_request_zero_in(dma0), .adc_trigger_in(adc_trig));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic final_report();
        $display("compares=%0d n_fail=%0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : final_report

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 64);
        if (pready !== 1'b1) begin
            n_fail++;
            final_report();
        end
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // drive enables and driven values; undriven pins are masked out
    task automatic pins(input logic [7:0] oe_b, input logic [7:0] val);
        @(negedge clk);
        chk({24'h0, pin_oe_b}, {24'h0, oe_b});
        chk({24'h0, pin_out & ~pin_oe_b}, {24'h0, val & ~oe_b});
    endtask : pins

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_gpio();
        pins(8'hff, 8'h00);
        apb(1'b0, A_DATA, 32'h0);
        chk(rd, {24'h0, EXT});
        apb(1'b1, A_DATA, 32'h0000_00a5);
        apb(1'b1, A_DIR, 32'h0000_000f);
        pins(8'hf0, 8'ha5);
        apb(1'b0, A_DATA, 32'h0);
        chk(rd, {24'h0, EXT[7:4], 4'h5});
        apb(1'b0, A_DIR, 32'h0);
        chk(rd, 32'hffff_ffff);
        chk({31'h0, err}, 32'h0);
        apb(1'b1, A_NONE, 32'h0000_00ff);
        chk({31'h0, err}, 32'h1);
        apb(1'b0, A_NONE, 32'h0);
        chk(rd, 32'h0);
        pins(8'hf0, 8'ha5);
        $display("test gpio done");
    endtask : t_gpio

    task automatic t_standby();
        @(posedge clk);
        sw_standby <= 1'b1;
        repeat (4) @(posedge clk);
        pins(8'hf0, 8'ha5);
        apb(1'b0, A_DATA, 32'h0);
        chk(rd, {24'h0, EXT[7:4], 4'h5});
        sw_standby <= 1'b0;
        apb(1'b1, A_DIR, 32'h0000_00ff);
        @(posedge clk);
        hw_standby <= 1'b1;
        repeat (2) @(posedge clk);
        pins(8'hff, 8'h00);
        @(posedge clk);
        hw_standby <= 1'b0;
        apb(1'b0, A_DATA, 32'h0);
        chk(rd, {24'h0, EXT});
        apb(1'b1, A_DIR, 32'h0000_00ff);
        apb(1'b0, A_DATA, 32'h0);
        chk(rd, 32'h0);
        $display("test standby done");
    endtask : t_standby

    task automatic t_shared();
        apb(1'b1, A_DIR, 32'h0);
        tc_en  <= 2'b11;
        tc_val <= 2'b10;
        cc_oe  <= 4'hf;
        cc_val <= 4'ha;
        pins(8'hc0, 8'h2a);
        chk({28'h0, cc_in}, 32'ha);
        chk({29'h0, dma1, dma0, adc_trig}, {29'h0, EXT[7], EXT[6], EXT[7]});
        @(posedge clk);
        tc_en   <= 2'b00;
        cc_oe   <= 4'h0;
        pat_en  <= 8'hff;
        pat_val <= 8'h96;
        pins(8'hff, 8'h00);
        apb(1'b1, A_DIR, 32'h0000_00f0);
        pins(8'h0f, 8'h90);
        @(posedge clk);
        pat_en <= 8'h00;
        $display("test shared done");
    endtask : t_shared

    task automatic t_cs7();
        apb(1'b1, A_DIR, 32'h0);
        cs7_en  <= 1'b1;
        cs7_val <= 1'b1;
        for (int m = 0; m <= 7; m++) begin
            @(posedge clk);
            op_mode <= 3'(m);
            pins((m == 0 || m == 7) ? 8'hff : 8'hbf, 8'h40);
        end
        @(posedge clk);
        cs7_en <= 1'b0;
        $display("test cs7 done");
    endtask : t_cs7

    task automatic t_reset();
        apb(1'b1, A_DATA, 32'h0000_003c);
        apb(1'b1, A_DIR, 32'h0000_00ff);
        pins(8'h00, 8'h3c);
        @(posedge clk);
        rst_b <= 1'b0;
        repeat (2) @(posedge clk);
        pins(8'hff, 8'h00);
        @(posedge clk);
        rst_b <= 1'b1;
        apb(1'b0, A_DATA, 32'h0);
        chk(rd, {24'h0, EXT});
        apb(1'b1, A_DIR, 32'h0000_00ff);
        apb(1'b0, A_DATA, 32'h0);
        chk(rd, 32'h0);
        $display("test reset done");
    endtask : t_reset

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (16) @(posedge clk);
        rst_b <= 1'b1;
        t_gpio();
        t_standby();
        t_shared();
        t_cs7();
        t_reset();
        final_report();
    end
endmodule : port_b_gpio_pin_mux_test
